// ===== pkg/qct_pkg.sv
// qct_pkg: shared constants and types for the queued command tag tracker.
// assumes a single 25 MHz clock domain shared by link logic and media logic.
package qct_pkg;

    // tag space: one bit per queued command tag
    localparam int QCT_TAG_W = 5;
    localparam int QCT_TAG_N = 32;

    // data path widths and buffer depth
    localparam int QCT_DATA_W = 32;
    localparam int QCT_FIFO_DEPTH = 16;

    // reset values of the tracking state
    localparam logic [31:0] QCT_PEND_RST = 32'h0000_0000;
    localparam logic QCT_BUSY_RST = 1'b0;

    // kinds of frame the device sends to the host
    typedef enum logic [2:0] {
        QCT_FIS_NONE = 3'h0,
        QCT_FIS_REG = 3'h1,
        QCT_FIS_SETUP = 3'h2,
        QCT_FIS_SDB = 3'h4
    } qct_fis_kind_e;

    // frame towards the host: register, dma setup or set device bits
    typedef struct packed {
        qct_fis_kind_e kind;
        logic busy_flag;
        logic irq;
        logic [QCT_TAG_W-1:0] buffer_tag_field;
        logic [QCT_TAG_N-1:0] active_field;
    } qct_fis_s;

    // one data word with its end marker
    typedef struct packed {
        logic last;
        logic [QCT_DATA_W-1:0] data;
    } qct_word_s;

    // queued read command received from the host
    typedef struct packed {
        logic [QCT_TAG_W-1:0] tag;
    } qct_cmd_s;

    // tracker states, one-hot
    typedef enum logic [4:0] {
        QCT_ST_IDLE = 5'h01,
        QCT_ST_REL = 5'h02,
        QCT_ST_SETUP = 5'h04,
        QCT_ST_DATA = 5'h08,
        QCT_ST_DONE = 5'h10
    } qct_state_e;

endpackage

// ===== hw/qct_fifo.sv
// qct_fifo: parameterised word buffer with valid/ready on both sides.
// assumes one clock, synchronous active-low reset and a clock enable.
`timescale 1ns/1ps
module qct_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    // depth must be a power of two for pointer wrap
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        $error("qct_fifo: DEPTH must be a power of two of at least 2");

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    wire push = in_valid && in_ready;
    wire pop = (count != '0) && (!out_valid || out_ready);

    // words held in memory, excluding the output register
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    // storage write side
    always_ff @(posedge ref_clk)
    begin
        if (clk_en && push)
            mem[wr_ptr] <= in_data;
    end

    // pointers, fill level and registered output stage
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else if (clk_en)
        begin
            if (push)
                wr_ptr <= wr_ptr + AW'(1);
            if (pop)
            begin
                rd_ptr <= rd_ptr + AW'(1);
                out_data <= mem[rd_ptr];
            end
            if (pop)
                out_valid <= 1'b1;
            else if (out_ready)
                out_valid <= 1'b0;
            count <= next_count;
            in_ready <= next_count != (AW+1)'(DEPTH); // back-pressure when full
        end
    end
endmodule // qct_fifo

// ===== hw/qct_top.sv
// qct_top: device-side tracker for queued read commands by tag.
// assumes the link layer delivers received commands and takes frames and
// data words on ref_clk, and a media engine streams read data per tag.
//
// Overview of operation
// RQ1: host sets tag bit, then sends command
// RQ2: host keeps other outstanding tag bits set
// RQ3: host waits for busy clear before next
// RQ4: device releases busy before any data
// RQ5: setup frame names chosen tag, any order
// RQ6: host loads descriptor for named buffer
// RQ7: device sends data of the announced tag
// RQ8: host stores data in last announced buffer
// RQ9: completion frame: interrupt, one-hot finished tag
// RQ10: host clears completed bits and interrupts
// RQ11: host software retires deasserted tags
// RQ12: host never reuses a still-set tag
// RQ13: tag fields are 32 bits, tags 0-31
`timescale 1ns/1ps
module qct_top #(
    parameter int FIFO_DEPTH = qct_pkg::QCT_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // queued read command received from the host
    input wire logic cmd_valid,
    input wire qct_pkg::qct_cmd_s cmd,
    output logic cmd_ready,
    // frames towards the host
    output qct_pkg::qct_fis_s fis,
    output logic fis_valid,
    input wire logic fis_ready,
    // media read request and returned words
    output logic media_req,
    output logic [qct_pkg::QCT_TAG_W-1:0] media_tag,
    input wire qct_pkg::qct_word_s media_word,
    input wire logic media_valid,
    output logic media_ready,
    // read data towards the host
    output qct_pkg::qct_word_s tx_word,
    output logic tx_valid,
    input wire logic tx_ready,
    // status
    output logic [qct_pkg::QCT_TAG_N-1:0] pending_tags,
    output logic busy_flag
);
    import qct_pkg::*;

    if (FIFO_DEPTH < 2)
        $error("qct_top: FIFO_DEPTH must be at least 2");

    // one-hot decode of a tag, used for setting and for reporting
    function automatic logic [QCT_TAG_N-1:0] tag_bit(input logic [QCT_TAG_W-1:0] t);
        tag_bit = QCT_TAG_N'(1) << t;
    endfunction

    // highest pending tag wins, so service need not follow issue order
    function automatic logic [QCT_TAG_W-1:0] pick_tag(input logic [QCT_TAG_N-1:0] p);
        pick_tag = '0;
        for (int i = 0; i < QCT_TAG_N; i++)
            if (p[i])
                pick_tag = QCT_TAG_W'(i);
    endfunction

    qct_state_e state;
    qct_state_e next_state;
    logic [QCT_TAG_W-1:0] cur_tag;
    logic fifo_in_ready;
    logic fifo_out_valid;
    qct_word_s fifo_out_word;

    // handshakes and decoded conditions
    wire cmd_take = cmd_valid && cmd_ready;
    wire fis_done = fis_valid && fis_ready;
    wire media_take = media_valid && media_ready;
    wire media_end = media_take && media_word.last;
    wire tx_end = tx_valid && tx_ready && tx_word.last;
    wire [QCT_TAG_N-1:0] new_bit = tag_bit(cmd.tag); // RQ13
    wire [QCT_TAG_N-1:0] cur_bit = tag_bit(cur_tag); // RQ13
    wire [QCT_TAG_W-1:0] chosen = pick_tag(pending_tags);
    wire in_idle = state == QCT_ST_IDLE;
    wire can_take = in_idle && !busy_flag;
    wire fifo_pull = tx_ready || !tx_valid;

    // next state of the tracker
    always_comb
    begin
        next_state = state;
        case (state)
            QCT_ST_IDLE:
            begin
                if (busy_flag)
                    next_state = QCT_ST_REL; // RQ4
                else if (pending_tags != '0 && !cmd_valid)
                    next_state = QCT_ST_SETUP; // RQ5
            end
            QCT_ST_REL:
            begin
                if (fis_done)
                    next_state = QCT_ST_IDLE;
            end
            QCT_ST_SETUP:
            begin
                if (fis_done)
                    next_state = QCT_ST_DATA; // RQ7
            end
            QCT_ST_DATA:
            begin
                if (tx_end)
                    next_state = QCT_ST_DONE; // RQ9
            end
            QCT_ST_DONE:
            begin
                if (fis_done)
                    next_state = QCT_ST_IDLE;
            end
            default: next_state = QCT_ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            state <= QCT_ST_IDLE;
        else if (clk_en)
            state <= next_state;
    end

    // command acceptance: only while idle with busy already released
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            cmd_ready <= 1'b0;
        else if (clk_en)
            cmd_ready <= (next_state == QCT_ST_IDLE) && !cmd_take && !busy_flag;
    end

    // busy rises on a taken command and falls once the release frame went out
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            busy_flag <= QCT_BUSY_RST;
        else if (clk_en)
        begin
            if (cmd_take && can_take)
                busy_flag <= 1'b1;
            else if (state == QCT_ST_REL && fis_done)
                busy_flag <= 1'b0; // RQ4
        end
    end

    // outstanding tags: set on command, cleared when completion is sent
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            pending_tags <= QCT_PEND_RST;
        else if (clk_en)
        begin
            pending_tags <= (pending_tags
                & ~((state == QCT_ST_DONE && fis_done) ? cur_bit : '0))
                | ((cmd_take && can_take) ? new_bit : '0); // RQ13
        end
    end

    // tag under service, latched when leaving idle for setup
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            cur_tag <= '0;
        else if (clk_en && in_idle && next_state == QCT_ST_SETUP)
            cur_tag <= chosen; // RQ5
    end

    // frame builder: a frame stands until the link takes it
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            fis_valid <= 1'b0;
            fis <= '0;
        end
        else if (clk_en)
        begin
            if (fis_done)
                fis_valid <= 1'b0;
            if (in_idle && next_state == QCT_ST_REL)
            begin
                fis_valid <= 1'b1;
                fis <= '{kind: QCT_FIS_REG, busy_flag: 1'b0, irq: 1'b0,
                    buffer_tag_field: '0, active_field: '0}; // RQ4
            end
            else if (in_idle && next_state == QCT_ST_SETUP)
            begin
                fis_valid <= 1'b1;
                fis <= '{kind: QCT_FIS_SETUP, busy_flag: 1'b0, irq: 1'b0,
                    buffer_tag_field: chosen, active_field: '0}; // RQ5
            end
            else if (state == QCT_ST_DATA && tx_end)
            begin
                fis_valid <= 1'b1;
                fis <= '{kind: QCT_FIS_SDB, busy_flag: 1'b0, irq: 1'b1,
                    buffer_tag_field: cur_tag, active_field: cur_bit}; // RQ9
            end
        end
    end

    // media request: raised after the setup frame, dropped on the last word
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            media_req <= 1'b0;
            media_tag <= '0;
        end
        else if (clk_en)
        begin
            if (state == QCT_ST_SETUP && fis_done)
            begin
                media_req <= 1'b1; // RQ7
                media_tag <= cur_tag;
            end
            else if (media_end)
                media_req <= 1'b0;
        end
    end

    // media ready follows the buffer, gated to the data phase
    assign media_ready = fifo_in_ready && media_req;

    // buffer between media and link, back-pressured by the link
    qct_fifo #(
        .WIDTH($bits(qct_word_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .in_data(media_word),
        .in_valid(media_valid && media_req),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pull)
    );

    // output word register towards the link
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            tx_valid <= 1'b0;
            tx_word <= '0;
        end
        else if (clk_en && fifo_pull)
        begin
            tx_valid <= fifo_out_valid; // RQ7
            tx_word <= fifo_out_word;
        end
    end
endmodule // qct_top

// ===== sim/qct_assertions.sv
// qct_checker: timing checks on the ports of qct_top.
// assumes one clock domain; all properties pause while in reset or frozen.
`timescale 1ns/1ps
module qct_checker
    import qct_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic cmd_valid,
    input wire qct_pkg::qct_cmd_s cmd,
    input wire logic cmd_ready,
    input wire qct_pkg::qct_fis_s fis,
    input wire logic fis_valid,
    input wire logic fis_ready,
    input wire logic media_req,
    input wire logic [qct_pkg::QCT_TAG_W-1:0] media_tag,
    input wire logic media_ready,
    input wire qct_pkg::qct_word_s tx_word,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [qct_pkg::QCT_TAG_N-1:0] pending_tags,
    input wire logic busy_flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn || !clk_en);
    // release frame two cycles after a taken command
    chk_release_frame: assert property (cmd_valid && cmd_ready |=> busy_flag ##1
        fis_valid && fis.kind == QCT_FIS_REG && !fis.busy_flag) else $error("no release frame");
    chk_busy_drop: assert property (fis_valid && fis_ready && fis.kind == QCT_FIS_REG
        |=> !busy_flag) else $error("busy kept after release");
    chk_no_data_busy: assert property (busy_flag |-> !tx_valid && !media_req)
        else $error("data while busy");
    chk_setup_pending: assert property (fis_valid && fis.kind == QCT_FIS_SETUP
        |-> pending_tags[fis.buffer_tag_field]) else $error("setup for idle tag");
    chk_frame_hold: assert property (fis_valid && !fis_ready |=> fis_valid && $stable(fis))
        else $error("frame changed before taken");
    chk_media_tag: assert property (fis_valid && fis_ready && fis.kind == QCT_FIS_SETUP
        |=> media_req && media_tag == $past(fis.buffer_tag_field)) else $error("wrong media tag");
    chk_sdb_onehot: assert property (fis_valid && fis.kind == QCT_FIS_SDB
        |-> fis.irq && $onehot(fis.active_field) && fis.active_field[media_tag])
        else $error("bad completion frame");
    chk_sdb_clears: assert property (fis_valid && fis_ready && fis.kind == QCT_FIS_SDB
        |=> (pending_tags & $past(fis.active_field)) == '0) else $error("tag not cleared");
    chk_last_sdb: assert property (tx_valid && tx_ready && tx_word.last
        |-> ##[1:2] fis_valid && fis.kind == QCT_FIS_SDB) else $error("no completion frame");
endmodule // qct_checker

// ===== sim/qct_host_model.sv
// qct_host_model: host end of the link, keeps the active tag copy.
// assumes the bench queues tags through issue() after reset.
`timescale 1ns/1ps
module qct_host_model
    import qct_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic tx_stall,
    input wire logic cmd_ready,
    input wire logic busy_flag,
    input wire qct_pkg::qct_fis_s fis,
    input wire logic fis_valid,
    input wire qct_pkg::qct_word_s tx_word,
    input wire logic tx_valid,
    output logic cmd_valid,
    output qct_pkg::qct_cmd_s cmd,
    output logic fis_ready,
    output logic tx_ready
);
    logic [31:0] active_tag_register = '0;
    logic [31:0] last_done = '0;
    logic [31:0] retired = '0;
    logic [31:0] set_m;
    logic [31:0] clr_m;
    logic [4:0] buf_sel = '0;
    logic [4:0] q[$];
    int irqs = 0;
    int beats = 0;
    int bad = 0;
    initial cmd_valid = 1'b0;
    initial cmd = '0;
    initial fis_ready = 1'b0;
    initial tx_ready = 1'b0;
    // queue a read; a tag still outstanding is not reused
    task automatic issue(input logic [4:0] t);
        if (!active_tag_register[t]) q.push_back(t);
    endtask
    // issue commands, take frames and data on the rising edge
    always @(posedge ref_clk)
    begin
        set_m = '0;
        clr_m = '0;
        fis_ready <= 1'b1;
        tx_ready <= !tx_stall;
        if (!resetn)
        begin
            q.delete();
            cmd_valid <= 1'b0;
            active_tag_register <= '0;
            buf_sel <= '0;
            retired <= '0;
        end
        else
        begin
            if (cmd_valid && cmd_ready)
            begin
                void'(q.pop_front());
                cmd_valid <= 1'b0;
            end
            else if (!cmd_valid && q.size() > 0 && (!busy_flag ||
                (fis_valid && fis.kind == QCT_FIS_REG && !fis.busy_flag)))
            begin
                cmd.tag <= q[0];
                cmd_valid <= 1'b1;
                set_m = 32'h1 << q[0];
            end
            if (fis_valid && fis.kind == QCT_FIS_SETUP)
                buf_sel <= fis.buffer_tag_field;
            if (fis_valid && fis.kind == QCT_FIS_SDB && fis.irq)
            begin
                clr_m = fis.active_field;
                last_done <= fis.active_field;
                irqs <= irqs + 1;
            end
            active_tag_register <= (active_tag_register | set_m) & ~clr_m;
            // software reads the active tags after the interrupt, retires cleared ones
            retired <= last_done & ~active_tag_register;
            if (tx_valid && tx_ready)
            begin
                beats <= beats + 1;
                if (tx_word.data[31:27] !== buf_sel) bad <= bad + 1;
            end
        end
    end
endmodule // qct_host_model

// ===== sim/tb_queued_command_tag_tracking.sv
// tb_queued_command_tag_tracking: self-checking bench for qct_top.
// assumes qct_host_model on the link side and a media engine made here.
`timescale 1ns/1ps
module tb_queued_command_tag_tracking;
    import qct_pkg::*;
    localparam int LEN = 20; // words per read, more than the fifo holds
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic tx_stall = 1'b0;
    logic cmd_valid, cmd_ready, fis_valid, fis_ready, media_req, media_valid, media_ready;
    logic tx_valid, tx_ready, busy_flag;
    qct_cmd_s cmd;
    qct_fis_s fis;
    qct_word_s media_word, tx_word;
    logic [4:0] media_tag;
    logic [31:0] pending_tags;
    logic [7:0] mcnt = 8'h00;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    logic [31:0] snap;
    // rows: tag, expected completion field
    logic [36:0] rows [3] = '{{5'h00, 32'h1}, {5'h05, 32'h20}, {5'h1f, 32'h8000_0000}};
    always #20 ref_clk = ~ref_clk;
    qct_top #(.FIFO_DEPTH(16)) uut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .fis(fis),
        .fis_valid(fis_valid), .fis_ready(fis_ready), .media_req(media_req),
        .media_tag(media_tag), .media_word(media_word), .media_valid(media_valid),
        .media_ready(media_ready), .tx_word(tx_word), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .pending_tags(pending_tags), .busy_flag(busy_flag));
    qct_host_model host (.ref_clk(ref_clk), .resetn(resetn), .tx_stall(tx_stall),
        .cmd_ready(cmd_ready), .busy_flag(busy_flag), .fis(fis), .fis_valid(fis_valid),
        .tx_word(tx_word), .tx_valid(tx_valid), .cmd_valid(cmd_valid), .cmd(cmd),
        .fis_ready(fis_ready), .tx_ready(tx_ready));
    // media engine: LEN words per tag, tag in the top data bits
    assign media_valid = media_req && (mcnt < LEN);
    assign media_word = '{last: (mcnt == LEN - 1), data: {media_tag, 27'(mcnt)}};
    always @(posedge ref_clk)
        mcnt <= !media_req ? 8'h00 : mcnt + 8'(media_valid && media_ready);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t %s", $time, m);
            err_count++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_irq(input int k);
        while (host.irqs < k) @(posedge ref_clk);
    endtask
    // one read of tag t from issue to completion
    task automatic run_one(input logic [4:0] t, input logic [31:0] f);
        int k;
        int b;
        k = host.irqs + 1;
        b = host.beats;
        host.issue(t);
        wait_irq(k);
        @(posedge ref_clk);
        chk(32'(host.buf_sel), 32'(t), "setup tag");
        chk(host.last_done, f, "done field");
        chk(32'(host.beats - b), LEN, "beat count");
        chk(host.active_tag_register, 32'h0, "active clear");
        chk(pending_tags, 32'h0, "pending clear");
        chk(32'(host.bad), 32'h0, "data buffer");
        chk(host.retired, f, "retired tags");
        $display("test tag %0d done", t);
    endtask
    // cycle ceiling against hangs
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (8) @(posedge ref_clk);
        chk({busy_flag, fis_valid, cmd_ready, media_req}, 32'h0, "reset outputs");
        resetn <= 1'b1;
        @(posedge ref_clk); // host must see reset released before work is queued
        foreach (rows[i]) run_one(rows[i][36:32], rows[i][31:0]);
        // two queued tags with the link stalled: fifo fills, higher tag first
        n = host.irqs + 2;
        tx_stall <= 1'b1;
        host.issue(5'h00);
        host.issue(5'h05);
        while (pending_tags !== 32'h21) @(posedge ref_clk);
        chk(host.active_tag_register, 32'h21, "two outstanding");
        while (!(media_req === 1'b1 && media_ready === 1'b0)) @(posedge ref_clk);
        chk(32'(host.buf_sel), 32'h5, "served out of order");
        // freeze: link free to take words, yet nothing may move while clk_en is low
        clk_en <= 1'b0;
        tx_stall <= 1'b0;
        @(posedge ref_clk);
        snap = tx_word.data;
        repeat (4) @(posedge ref_clk);
        chk(tx_word.data, snap, "frozen word");
        chk(pending_tags, 32'h21, "frozen pending");
        chk({31'h0, media_req}, 32'h1, "frozen request");
        clk_en <= 1'b1;
        $display("test clock enable freeze done");
        wait_irq(n);
        @(posedge ref_clk);
        chk(host.last_done, 32'h1, "second done");
        chk(host.active_tag_register, 32'h0, "both retired");
        $display("test queued pair done");
        // reset in mid transfer, then a clean read
        host.issue(5'h03);
        while (media_req !== 1'b1) @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(pending_tags, 32'h0, "reset pending");
        chk({busy_flag, fis_valid, media_req, tx_valid}, 32'h0, "reset idle");
        resetn <= 1'b1;
        @(posedge ref_clk); // host must see reset released before work is queued
        run_one(5'h03, 32'h8);
        stop_test();
    end
endmodule // tb_queued_command_tag_tracking
bind qct_top qct_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.ref_clk(ref_clk), .resetn(resetn),
    .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .fis(fis),
    .fis_valid(fis_valid), .fis_ready(fis_ready), .media_req(media_req),
    .media_tag(media_tag), .media_ready(media_ready), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .pending_tags(pending_tags),
    .busy_flag(busy_flag));
